// file: logic/ieu_regs.svh
// Constants of the instruction execution unit: offsets, fields, counts.
// Included by the core only, not by the package; holds definitions only.
// Behaviour
// - Memory destination costs one extra cycle for RAM, none for system reg
// - A taken conditional skip costs one extra cycle, an untaken none
// - Add sets carry on carry out, else clears; add-with-carry adds carry
// - Subtract clears carry on borrow, sets it otherwise
// - Subtract-with-borrow also subtracts inverted carry, to acc or memory
// - Table read loads ROM word at Y:Z into R and acc, two cycles
// - Compare computes acc minus operand, sets Z and C, skips on equal
// - Compare against memory skips on equal at one extra cycle
// - Increment/decrement to acc leaves memory, skips on zero result
// - Increment/decrement in memory writes back, skips on zero, RAM penalty
// - Bit test clear form skips when bit is 0, flags untouched
// - Bit test set form skips when bit is 1, flags untouched
// - Bank-zero forms always address bank 0
// - Jump loads PC low 14 bits from operand, top two from page bits
// - Call pushes full 16-bit PC+1 then loads PC like jump, two cycles
// - Return restores PC in two cycles; interrupt return also sets GIE
// - Context push saves acc and flags, not timeout/power-down, one cycle
// - Context pop restores acc and flags, timeout/power-down untouched
// - Nibble swap in memory writes back; acc form writes the accumulator
`ifndef IEU_REGS_SVH
`define IEU_REGS_SVH

`define IEU_REG_CTRL      12'h000
`define IEU_REG_PC        12'h004
`define IEU_REG_CORE      12'h008
`define IEU_CTRL_RUN      0
`define IEU_CTRL_GIE      1
`define IEU_CTRL_RST      32'h0000_0001
`define IEU_CTRL_RUN_RST  1'b1
`define IEU_FLG_Z         0
`define IEU_FLG_DC        1
`define IEU_FLG_C         2
`define IEU_FLG_NPD       6
`define IEU_FLG_NT0       7
`define IEU_SYSREG_LIMIT  8'h80
`define IEU_STACK_DEPTH   8
`define IEU_SP_W          3
`define IEU_CLK_NS        40
`define IEU_PC_RST        16'h0000

`endif

// file: logic/ieu_pkg.sv
// Types of the instruction execution unit.
// Opcode codes follow declaration order, word layout in ieu_core.
package ieu_pkg;
  typedef enum logic [5:0] {
    OP_NOP, OP_MOV_AM, OP_MOV_MA, OP_B0MOV_AM, OP_B0MOV_MA, OP_MOV_AI,
    OP_XCH, OP_B0XCH, OP_TABLE, OP_ADC_AM, OP_ADC_MA, OP_ADD_AM,
    OP_ADD_MA, OP_BANK_ZERO_ADD_TO_MEMORY_MA, OP_ADD_AI, OP_SBB_AM, OP_SBB_MA, OP_SUB_AM,
    OP_SUB_MA, OP_SUB_AI, OP_AND_AM, OP_AND_MA, OP_AND_AI, OP_OR_AM,
    OP_OR_MA, OP_OR_AI, OP_XOR_AM, OP_XOR_MA, OP_XOR_AI, OP_SWAP,
    OP_NIBBLE_SWAP_IN_MEMORY, OP_RRC, OP_RRCM, OP_RLC, OP_RLCM, OP_CLR, OP_CMP_AI,
    OP_CMP_AM, OP_INC_A, OP_INC_M, OP_DEC_A, OP_DEC_M, OP_RET, OP_RETURN_FROM_INTERRUPT,
    OP_PUSH, OP_POP
  } ieu_op_t;

  typedef enum logic [2:0] {
    ST_HALT, ST_EXEC, ST_WB, ST_SKIP, ST_BRANCH, ST_TABLE
  } ieu_state_t;
endpackage

// file: logic/ieu_core.sv
// Instruction execution unit: fetch, execute, stack, flags, APB status.
// Program ROM and data memory answer combinationally in the same cycle.
`timescale 1ns/1ps
`include "ieu_regs.svh"
module ieu_core (
  input  wire logic        CLK_SYS,   // Instruction-cycle clock
  input  wire logic        RST,       // Async reset, active high
  output logic [15:0]      ROM_ADDR,  // Program ROM address
  input  wire logic [15:0] ROM_DATA,  // Program ROM word
  input  wire logic [1:0]  ROM_PAGE,  // ROM page bits for jump/call
  input  wire logic [7:0]  Y_IN,      // Table pointer high byte
  input  wire logic [7:0]  Z_IN,      // Table pointer low byte
  input  wire logic        NT0_IN,    // Timeout status bit
  input  wire logic        NPD_IN,    // Power-down status bit
  output logic [7:0]       MEM_ADDR,  // Data memory address
  output logic             MEM_BANK0, // Force bank 0
  input  wire logic [7:0]  MEM_RDATA, // Data memory read data
  output logic [7:0]       MEM_WDATA, // Data memory write data
  output logic             MEM_WE,    // Data memory write strobe
  output logic [7:0]       R_OUT,     // Table read high byte
  output logic [7:0]       ACC_OUT,   // Accumulator
  output logic [7:0]       PROGRAM_FLAG_REGISTER_OUT, // Program flag register
  output logic             GIE_OUT,   // Global interrupt enable
  input  wire logic        PSEL,      // APB select
  input  wire logic        PENABLE,   // APB enable
  input  wire logic        PWRITE,    // APB direction
  input  wire logic [11:0] PADDR,     // APB byte address
  input  wire logic [31:0] PWDATA,    // APB write data
  output logic [31:0]      PRDATA,    // APB read data
  output logic             PREADY,    // APB ready
  output logic             PSLVERR    // APB error
);
  import ieu_pkg::*;

  ieu_state_t st_q;
  ieu_op_t    op;
  logic [15:0] pc_q;
  logic [7:0]  acc_q;
  logic [7:0]  r_q;
  logic        c_q;
  logic        dc_q;
  logic        z_q;
  logic        gie_q;
  logic        run_q;
  logic [7:0]  acc_sh_q;
  logic [5:0]  flg_sh_q;
  logic [15:0] stk [`IEU_STACK_DEPTH];
  logic [`IEU_SP_W-1:0] sp_q;
  logic [7:0]  wb_addr_q;
  logic [7:0]  wb_data_q;
  logic        wb_b0_q;
  logic        skip_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  // Word layout: 10=jump, 11=call, 01=bit op, 00=opcode in [13:8]
  logic        is_jmp;
  logic        is_call;
  logic        is_bit;
  logic [2:0]  bitop;
  logic [2:0]  bitn;
  logic        go;
  logic        sys;
  logic        use_imm;
  logic [7:0]  src;
  logic        cin;
  logic        bin;
  logic [8:0]  add9;
  logic [8:0]  sub9;
  logic [4:0]  addn;
  logic [4:0]  subn;
  logic [7:0]  inc8;
  logic [7:0]  dec8;

  assign is_jmp  = ROM_DATA[15:14] == 2'b10;
  assign is_call = ROM_DATA[15:14] == 2'b11;
  assign is_bit  = ROM_DATA[15:14] == 2'b01;
  assign bitop   = ROM_DATA[13:11];
  assign bitn    = ROM_DATA[10:8];
  assign op      = ieu_op_t'(ROM_DATA[13:8]);
  assign go      = (st_q == ST_EXEC) && run_q;
  assign sys     = ROM_DATA[7:0] < `IEU_SYSREG_LIMIT;
  assign use_imm = !is_bit && (op inside {OP_MOV_AI, OP_ADD_AI, OP_SUB_AI,
                   OP_AND_AI, OP_OR_AI, OP_XOR_AI, OP_CMP_AI});
  assign src     = use_imm ? ROM_DATA[7:0] : MEM_RDATA;
  assign cin     = (op inside {OP_ADC_AM, OP_ADC_MA}) ? c_q : 1'b0;
  assign bin     = (op inside {OP_SBB_AM, OP_SBB_MA}) ? ~c_q : 1'b0;
  assign add9 = {1'b0, acc_q} + {1'b0, src} + {8'h00, cin};
  assign sub9 = {1'b0, acc_q} - {1'b0, src} - {8'h00, bin};
  assign addn = {1'b0, acc_q[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
  assign subn = {1'b0, acc_q[3:0]} - {1'b0, src[3:0]} - {4'h0, bin};
  assign inc8 = MEM_RDATA + 8'h01;
  assign dec8 = MEM_RDATA - 8'h01;

  // Decoded effects of the word at the PC
  logic       x_acc_we;
  logic [7:0] x_acc;
  logic       x_mem_we;
  logic [7:0] x_mem;
  logic       x_b0;
  logic       x_c_we;
  logic       x_c;
  logic       x_dc_we;
  logic       x_z_we;
  logic       x_z;
  logic       x_skip;

  always_comb begin
    x_acc_we = 1'b0;
    x_acc    = acc_q;
    x_mem_we = 1'b0;
    x_mem    = MEM_RDATA;
    x_b0     = 1'b0;
    x_c_we   = 1'b0;
    x_c      = c_q;
    x_dc_we  = 1'b0;
    x_z_we   = 1'b0;
    x_z      = z_q;
    x_skip   = 1'b0;
    if (is_bit) begin
      x_b0 = bitop[1];
      if (bitop[2]) begin
        x_skip = MEM_RDATA[bitn] == bitop[0];
      end else begin
        x_mem_we = 1'b1;
        x_mem[bitn] = bitop[0];
      end
    end else if (!is_jmp && !is_call) begin
      case (op)
        OP_MOV_AM, OP_B0MOV_AM: begin
          x_acc_we = 1'b1;
          x_acc    = MEM_RDATA;
          x_z_we   = 1'b1;
          x_z      = MEM_RDATA == 8'h00;
        end
        OP_MOV_MA, OP_B0MOV_MA: begin
          x_mem_we = 1'b1;
          x_mem    = acc_q;
        end
        OP_MOV_AI: begin
          x_acc_we = 1'b1;
          x_acc    = src;
        end
        OP_XCH, OP_B0XCH: begin
          x_acc_we = 1'b1;
          x_acc    = MEM_RDATA;
          x_mem_we = 1'b1;
          x_mem    = acc_q;
        end
        OP_ADC_AM, OP_ADD_AM, OP_ADD_AI, OP_ADC_MA, OP_ADD_MA,
        OP_BANK_ZERO_ADD_TO_MEMORY_MA: begin
          x_acc_we = op inside {OP_ADC_AM, OP_ADD_AM, OP_ADD_AI};
          x_mem_we = !x_acc_we;
          x_acc    = add9[7:0];
          x_mem    = add9[7:0];
          x_c_we   = 1'b1;
          x_c      = add9[8];
          x_dc_we  = 1'b1;
          x_z_we   = 1'b1;
          x_z      = add9[7:0] == 8'h00;
        end
        OP_SBB_AM, OP_SUB_AM, OP_SUB_AI, OP_SBB_MA, OP_SUB_MA: begin
          x_acc_we = op inside {OP_SBB_AM, OP_SUB_AM, OP_SUB_AI};
          x_mem_we = !x_acc_we;
          x_acc    = sub9[7:0];
          x_mem    = sub9[7:0];
          x_c_we   = 1'b1;
          x_c      = ~sub9[8];
          x_dc_we  = 1'b1;
          x_z_we   = 1'b1;
          x_z      = sub9[7:0] == 8'h00;
        end
        OP_AND_AM, OP_AND_AI, OP_AND_MA, OP_OR_AM, OP_OR_AI, OP_OR_MA,
        OP_XOR_AM, OP_XOR_AI, OP_XOR_MA: begin
          if (op inside {OP_AND_AM, OP_AND_AI, OP_AND_MA}) begin
            x_acc = acc_q & src;
          end else if (op inside {OP_OR_AM, OP_OR_AI, OP_OR_MA}) begin
            x_acc = acc_q | src;
          end else begin
            x_acc = acc_q ^ src;
          end
          x_mem    = x_acc;
          x_mem_we = op inside {OP_AND_MA, OP_OR_MA, OP_XOR_MA};
          x_acc_we = !x_mem_we;
          x_z_we   = 1'b1;
          x_z      = x_acc == 8'h00;
        end
        OP_SWAP, OP_NIBBLE_SWAP_IN_MEMORY: begin
          x_acc_we = op == OP_SWAP;
          x_mem_we = op == OP_NIBBLE_SWAP_IN_MEMORY;
          x_acc    = {MEM_RDATA[3:0], MEM_RDATA[7:4]};
          x_mem    = x_acc;
        end
        OP_RRC, OP_RRCM, OP_RLC, OP_RLCM: begin
          x_acc_we = op inside {OP_RRC, OP_RLC};
          x_mem_we = !x_acc_we;
          x_c_we   = 1'b1;
          if (op inside {OP_RRC, OP_RRCM}) begin
            x_acc = {c_q, MEM_RDATA[7:1]};
            x_c   = MEM_RDATA[0];
          end else begin
            x_acc = {MEM_RDATA[6:0], c_q};
            x_c   = MEM_RDATA[7];
          end
          x_mem = x_acc;
        end
        OP_CLR: begin
          x_mem_we = 1'b1;
          x_mem    = 8'h00;
        end
        OP_CMP_AI, OP_CMP_AM: begin
          x_c_we = 1'b1;
          x_c    = ~sub9[8];
          x_z_we = 1'b1;
          x_z    = sub9[7:0] == 8'h00;
          x_skip = sub9[7:0] == 8'h00;
        end
        OP_INC_A, OP_INC_M, OP_DEC_A, OP_DEC_M: begin
          x_acc    = (op inside {OP_INC_A, OP_INC_M}) ? inc8 : dec8;
          x_mem    = x_acc;
          x_acc_we = op inside {OP_INC_A, OP_DEC_A};
          x_mem_we = !x_acc_we;
          x_skip   = x_acc == 8'h00;
        end
        default: begin
        end
      endcase
      x_b0 = op inside {OP_B0MOV_AM, OP_B0MOV_MA, OP_B0XCH,
                        OP_BANK_ZERO_ADD_TO_MEMORY_MA};
    end
  end

  // Memory port: system registers written at once, RAM in a second cycle
  always_comb begin
    if (st_q == ST_WB) begin
      MEM_ADDR  = wb_addr_q;
      MEM_BANK0 = wb_b0_q;
      MEM_WDATA = wb_data_q;
      MEM_WE    = 1'b1;
    end else begin
      MEM_ADDR  = ROM_DATA[7:0];
      MEM_BANK0 = x_b0;
      MEM_WDATA = x_mem;
      MEM_WE    = go && x_mem_we && sys;
    end
  end

  assign ROM_ADDR = (st_q == ST_TABLE) ? {Y_IN, Z_IN} : pc_q;

  // Sequencer and program counter
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q      <= ST_HALT;
      pc_q      <= `IEU_PC_RST;
      skip_q    <= 1'b0;
      wb_addr_q <= 8'h00;
      wb_data_q <= 8'h00;
      wb_b0_q   <= 1'b0;
    end else begin
      case (st_q)
        ST_HALT: begin
          if (run_q) begin
            st_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (!run_q) begin
            st_q <= ST_HALT;
          end else if (is_jmp || is_call) begin
            pc_q <= {ROM_PAGE, ROM_DATA[13:0]};
            st_q <= ST_BRANCH;
          end else if (!is_bit && (op inside {OP_RET, OP_RETURN_FROM_INTERRUPT})) begin
            pc_q <= stk[sp_q - `IEU_SP_W'(1)];
            st_q <= ST_BRANCH;
          end else begin
            pc_q      <= pc_q + 16'h0001;
            skip_q    <= x_skip;
            wb_addr_q <= ROM_DATA[7:0];
            wb_data_q <= x_mem;
            wb_b0_q   <= x_b0;
            if (x_mem_we && !sys) begin
              st_q <= ST_WB;
            end else if (x_skip) begin
              st_q <= ST_SKIP;
            end else if (!is_bit && op == OP_TABLE) begin
              st_q <= ST_TABLE;
            end
          end
        end
        ST_WB: begin
          st_q <= skip_q ? ST_SKIP : ST_EXEC;
        end
        ST_SKIP: begin
          pc_q <= pc_q + 16'h0001;
          st_q <= ST_EXEC;
        end
        default: begin
          st_q <= ST_EXEC;
        end
      endcase
    end
  end

  // Hardware stack
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sp_q <= '0;
    end else if (go && is_call) begin
      sp_q <= sp_q + `IEU_SP_W'(1);
    end else if (go && !is_bit && !is_jmp && (op inside {OP_RET, OP_RETURN_FROM_INTERRUPT}))
    begin
      sp_q <= sp_q - `IEU_SP_W'(1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (go && is_call) begin
      stk[sp_q] <= pc_q + 16'h0001;
    end
  end

  // Accumulator, R and context shadow
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      acc_q    <= 8'h00;
      r_q      <= 8'h00;
      acc_sh_q <= 8'h00;
      flg_sh_q <= 6'h00;
    end else if (st_q == ST_TABLE) begin
      r_q   <= ROM_DATA[15:8];
      acc_q <= ROM_DATA[7:0];
    end else if (go && !is_bit && !is_jmp && !is_call && op == OP_PUSH)
    begin
      acc_sh_q <= acc_q;
      flg_sh_q <= {3'b000, c_q, dc_q, z_q};
    end else if (go && !is_bit && !is_jmp && !is_call && op == OP_POP)
    begin
      acc_q <= acc_sh_q;
    end else if (go && !is_jmp && !is_call && x_acc_we) begin
      acc_q <= x_acc;
    end
  end

  // Flags; NT0 and POWER_DOWN_STATUS_BIT live outside and are never saved or restored
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      c_q  <= 1'b0;
      dc_q <= 1'b0;
      z_q  <= 1'b0;
    end else if (go && !is_bit && !is_jmp && !is_call && op == OP_POP)
    begin
      c_q  <= flg_sh_q[`IEU_FLG_C];
      dc_q <= flg_sh_q[`IEU_FLG_DC];
      z_q  <= flg_sh_q[`IEU_FLG_Z];
    end else if (go && !is_jmp && !is_call) begin
      if (x_c_we) begin
        c_q <= x_c;
      end
      if (x_dc_we) begin
        dc_q <= (op inside {OP_SBB_AM, OP_SBB_MA, OP_SUB_AM, OP_SUB_MA,
                 OP_SUB_AI}) ? ~subn[4] : addn[4];
      end
      if (x_z_we) begin
        z_q <= x_z;
      end
    end
  end

  // Control register and interrupt enable; the return sets win over clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_q <= `IEU_CTRL_RUN_RST;
      gie_q <= 1'b0;
    end else begin
      if (PSEL && PENABLE && PWRITE && PADDR == `IEU_REG_CTRL) begin
        run_q <= PWDATA[`IEU_CTRL_RUN];
        gie_q <= PWDATA[`IEU_CTRL_GIE];
      end
      if (go && !is_bit && !is_jmp && !is_call && op == OP_RETURN_FROM_INTERRUPT) begin
        gie_q <= 1'b1;
      end
    end
  end

  // APB read data captured in the setup cycle, answer in the access cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (PADDR == `IEU_REG_CTRL) begin
        prdata_q <= {30'h0000_0000, gie_q, run_q};
      end else if (PADDR == `IEU_REG_PC) begin
        prdata_q <= {16'h0000, pc_q};
      end else if (PADDR == `IEU_REG_CORE) begin
        prdata_q <= {5'h00, st_q, 5'h00, sp_q, PROGRAM_FLAG_REGISTER_OUT, acc_q};
      end else begin
        pslverr_q <= 1'b1;
      end
    end
  end

  assign PREADY    = 1'b1;
  assign PRDATA    = prdata_q;
  assign PSLVERR   = pslverr_q && PSEL && PENABLE;
  assign R_OUT     = r_q;
  assign ACC_OUT   = acc_q;
  assign GIE_OUT   = gie_q;
  assign PROGRAM_FLAG_REGISTER_OUT = {NT0_IN, NPD_IN, 3'b000, c_q, dc_q, z_q};

  chk_ram_dest_wb: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && x_mem_we && !sys && !is_jmp && !is_call |=> st_q == ST_WB && MEM_WE)
    else $error("RAM destination without write-back cycle");
  chk_sys_dest_fast: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && x_mem_we && sys && !x_skip |-> MEM_WE ##1 st_q != ST_WB)
    else $error("System register write took extra cycle");
  chk_skip_one_cyc: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && x_skip && !(x_mem_we && !sys) |=> st_q == ST_SKIP ##1
    st_q != ST_SKIP && pc_q == $past(pc_q, 2) + 16'h0002)
    else $error("Skip did not cost exactly one cycle");
  chk_add_carry: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && !is_bit && !is_jmp && !is_call &&
    (op inside {OP_ADD_AM, OP_ADD_AI, OP_ADC_AM}) |=>
    {c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(src)} +
    {8'h00, $past(op == OP_ADC_AM) & $past(c_q)})
    else $error("Add carry or sum wrong");
  chk_sub_carry: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && !is_bit && !is_jmp && !is_call &&
    (op inside {OP_SUB_AM, OP_SUB_AI, OP_SBB_AM}) |=>
    c_q == ({1'b0, $past(acc_q)} >= {1'b0, $past(src)} +
    {8'h00, $past(op == OP_SBB_AM) & ~$past(c_q)}))
    else $error("Subtract carry not inverted borrow");
  chk_table_read: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && !is_bit && !is_jmp && !is_call && op == OP_TABLE |=>
    ROM_ADDR == {Y_IN, Z_IN} ##1 acc_q == $past(ROM_DATA[7:0]) &&
    st_q == ST_EXEC)
    else $error("Table read wrong");
  chk_cmp_equal: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && !is_bit && !is_jmp && !is_call &&
    (op inside {OP_CMP_AI, OP_CMP_AM}) && acc_q == src |=>
    st_q == ST_SKIP && z_q && c_q)
    else $error("Compare equal did not skip");
  chk_bit_no_flags: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && is_bit && bitop[2] |=> $stable({c_q, dc_q, z_q}) &&
    (st_q == ST_SKIP) == ($past(MEM_RDATA[bitn]) == $past(bitop[0])))
    else $error("Bit test wrong");
  chk_jump_target: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && (is_jmp || is_call) |=> st_q == ST_BRANCH &&
    pc_q == {$past(ROM_PAGE), $past(ROM_DATA[13:0])} ##1 st_q == ST_EXEC)
    else $error("Jump target or length wrong");
  chk_call_stack: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && is_call |=> stk[$past(sp_q)] == $past(pc_q) + 16'h0001)
    else $error("Call did not push PC");
  chk_return_from_interrupt_gie: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && !is_bit && !is_jmp && !is_call && op == OP_RETURN_FROM_INTERRUPT |=> gie_q &&
    st_q == ST_BRANCH)
    else $error("Interrupt return left GIE clear");
  chk_ctx_restore: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && !is_bit && !is_jmp && !is_call && op == OP_POP |=>
    acc_q == $past(acc_sh_q) && c_q == $past(flg_sh_q[`IEU_FLG_C]))
    else $error("Context pop wrong");
  chk_logic_keep_c: assert property (@(posedge CLK_SYS) disable iff (RST)
    go && !is_bit && !is_jmp && !is_call &&
    (op inside {OP_AND_AM, OP_OR_AI, OP_XOR_MA, OP_MOV_AM, OP_CLR,
                OP_XOR_AI, OP_MOV_AI, OP_MOV_MA}) |=>
    $stable(c_q) && $stable(dc_q))
    else $error("Logic op changed carry");
endmodule // ieu_core

// file: dv/ieu_mem_model.sv
// Program ROM and data RAM model for the execution unit.
// Reads answer in the same cycle; RAM writes land on the clock edge.
`timescale 1ns/1ps
module ieu_mem_model (
  input  wire logic        CLK_SYS,   // Instruction clock
  input  wire logic [15:0] ROM_ADDR,  // ROM address
  output logic [15:0]      ROM_DATA,  // ROM word
  input  wire logic [7:0]  MEM_ADDR,  // RAM address
  input  wire logic        MEM_BANK0, // Bank 0 force
  output logic [7:0]       MEM_RDATA, // RAM read data
  input  wire logic [7:0]  MEM_WDATA, // RAM write data
  input  wire logic        MEM_WE     // RAM write strobe
);
  logic [15:0] rom [0:255];
  logic [7:0]  ram [0:511];
  // Bank 0 in the low half, the selected bank 1 in the high half
  assign ROM_DATA  = rom[ROM_ADDR[7:0]];
  assign MEM_RDATA = ram[{~MEM_BANK0, MEM_ADDR}];
  always @(posedge CLK_SYS) begin
    if (MEM_WE) ram[{~MEM_BANK0, MEM_ADDR}] <= MEM_WDATA;
  end
endmodule // ieu_mem_model

// file: dv/instruction_execution_unit_tb.sv
// Self-checking bench: runs a program and probes status over APB.
// Assumes combinational ROM/RAM model and the core's APB map.
`timescale 1ns/1ps
module instruction_execution_unit_tb;
  import ieu_pkg::*;
  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic [15:0] ra, rd16;
  logic [7:0]  ma, mr, mw, r_o, acc, pf;
  logic        b0, we, gie, rdy, serr;
  logic        psel = 0, pen = 0, pwr = 0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        err;
  int          fails = 0, samples_checked = 0;

  ieu_core dut (.CLK_SYS(CLK_SYS), .RST(RST), .ROM_ADDR(ra),
    .ROM_DATA(rd16), .ROM_PAGE(2'h2), .Y_IN(8'h00), .Z_IN(8'h01),
    .NT0_IN(1'b1), .NPD_IN(1'b0), .MEM_ADDR(ma), .MEM_BANK0(b0),
    .MEM_RDATA(mr), .MEM_WDATA(mw), .MEM_WE(we), .R_OUT(r_o),
    .ACC_OUT(acc), .PROGRAM_FLAG_REGISTER_OUT(pf), .GIE_OUT(gie), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr));
  ieu_mem_model mdl (.CLK_SYS(CLK_SYS), .ROM_ADDR(ra), .ROM_DATA(rd16),
    .MEM_ADDR(ma), .MEM_BANK0(b0), .MEM_RDATA(mr), .MEM_WDATA(mw),
    .MEM_WE(we));

  always #20 CLK_SYS = ~CLK_SYS;

  function automatic logic [15:0] ins(ieu_op_t op, logic [7:0] b);
    return {2'b00, op, b};
  endfunction

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge CLK_SYS);
    psel <= 1'b1; pwr <= w; padr <= a; pwd <= d;
    @(posedge CLK_SYS);
    pen <= 1'b1;
    do @(posedge CLK_SYS); while (rdy !== 1'b1);
    rd = prd;
    err = serr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge CLK_SYS);
    fails++;
    end_of_test();
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      mdl.rom[i] = 16'h0000;
      mdl.ram[i] = 8'h00;
      mdl.ram[i + 256] = 8'h00;
    end
    mdl.ram[9'h190] = 8'h05;
    mdl.ram[9'h191] = 8'hFF;
    mdl.ram[9'h192] = 8'h01;
    mdl.ram[9'h193] = 8'hA5;
    mdl.ram[9'h195] = 8'hAA;
    mdl.rom[0] = ins(OP_MOV_AI, 8'hF0);  mdl.rom[1] = ins(OP_ADD_AI, 8'h20);
    mdl.rom[2] = ins(OP_ADC_MA, 8'h90);  mdl.rom[3] = ins(OP_SUB_AI, 8'h11);
    mdl.rom[4] = ins(OP_SBB_AM, 8'h90);  mdl.rom[5] = ins(OP_CMP_AI, 8'hE8);
    mdl.rom[7] = ins(OP_INC_M, 8'h91);   mdl.rom[9] = ins(OP_DEC_A, 8'h92);
    mdl.rom[11] = ins(OP_NIBBLE_SWAP_IN_MEMORY, 8'h93);
    mdl.rom[12] = {2'b01, 3'd5, 3'd1, 8'h93};
    mdl.rom[14] = {2'b01, 3'd6, 3'd1, 8'h93};
    foreach (mdl.rom[i]) if (i inside {6, 8, 10, 13, 15})
      mdl.rom[i] = ins(OP_MOV_MA, 8'h95);
    mdl.rom[16] = ins(OP_PUSH, 8'h00);   mdl.rom[17] = ins(OP_MOV_AI, 8'h3C);
    mdl.rom[18] = ins(OP_POP, 8'h00);    mdl.rom[19] = ins(OP_MOV_MA, 8'h94);
    mdl.rom[20] = ins(OP_TABLE, 8'h00);  mdl.rom[21] = {2'b11, 14'h0030};
    mdl.rom[22] = {2'b10, 14'd22};
    mdl.rom[48] = ins(OP_PUSH, 8'h00);
    mdl.rom[49] = ins(OP_MOV_AI, 8'h99);
    mdl.rom[50] = ins(OP_B0MOV_MA, 8'h97);
    mdl.rom[51] = ins(OP_XOR_AI, 8'hFF);
    mdl.rom[52] = ins(OP_MOV_MA, 8'h10);
    mdl.rom[53] = ins(OP_POP, 8'h00);
    mdl.rom[54] = ins(OP_RETURN_FROM_INTERRUPT, 8'h00);
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", {30'h0, rd[1:0]}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("unmapped", rd, 32'h0);
    while (gie !== 1'b1) @(posedge CLK_SYS);
    repeat (3) @(posedge CLK_SYS);
    chk("adc_mem", {24'h0, mdl.ram[9'h190]}, 32'h16);
    chk("inc_mem", {24'h0, mdl.ram[9'h191]}, 32'h00);
    chk("dec_mem", {24'h0, mdl.ram[9'h192]}, 32'h01);
    chk("swap_mem", {24'h0, mdl.ram[9'h193]}, 32'h5A);
    chk("skipped", {24'h0, mdl.ram[9'h195]}, 32'hAA);
    chk("pop_acc", {24'h0, mdl.ram[9'h194]}, 32'h00);
    chk("b0_mem", {24'h0, mdl.ram[9'h097]}, 32'h99);
    chk("sys_mem", {24'h0, mdl.ram[9'h110]}, 32'h66);
    chk("table_r", {24'h0, r_o}, {24'h0, mdl.rom[1][15:8]});
    chk("acc", {24'h0, acc}, 32'h20);
    chk("carry", {31'h0, pf[2]}, 32'h1);
    chk("status", {30'h0, pf[7:6]}, 32'h2);
    chk("gie", {31'h0, gie}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("pc", rd, 32'h0000_8016);
    apb(1'b0, 12'h008, 32'h0);
    chk("core", {13'h0, rd[18:0]}, 32'h0000_8720);
    apb(1'b1, 12'h000, 32'h1);
    @(posedge CLK_SYS);
    chk("gie_clr", {31'h0, gie}, 32'h0);
    end_of_test();
  end
endmodule // instruction_execution_unit_tb
